// *** core/afe_pkg.sv ***
// package: register map, field layout, reset values and timing for the afe spi config block
package afe_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int HDR_W = 16;
   localparam int FRAME_W = 24;
   localparam int NCHAN = 4;
   // register addresses
   localparam logic [12:0] ADDR_INTF_CONFIG = 13'h0000;
   localparam logic [12:0] ADDR_OFFSET_A = 13'h0010;
   localparam logic [12:0] ADDR_OFFSET_D = 13'h0013;
   localparam logic [12:0] ADDR_POWER_MODE = 13'h0014;
   localparam logic [12:0] ADDR_GAIN = 13'h0015;
   localparam logic [12:0] ADDR_CHAN_EN = 13'h0017;
   // reset values
   localparam logic [7:0] RST_INTF_CONFIG = 8'h00;
   localparam logic [5:0] RST_OFFSET = 6'h20;
   localparam logic [7:0] RST_POWER_MODE = 8'h0A;
   localparam logic [7:0] RST_GAIN = 8'h00;
   localparam logic [3:0] RST_CHAN_EN = 4'h0;
   // field positions
   localparam int BIT_ORDER_UPPER_POS = 5;
   localparam int BIT_ORDER_LOWER_POS = 2;
   localparam int HDR_RW_POS = 15;
   localparam int HDR_LEN_HI_POS = 14;
   localparam int HDR_LEN_LO_POS = 13;
   localparam int OFFSET_W = 6;
   localparam int BIAS_W = 2;
   localparam int GAIN_W = 2;
   // gain code to db: 18 + 6 * code
   localparam int GAIN_MIN_DB = 18;
   localparam int GAIN_STEP_DB = 6;
   // serial clock limit on the host side
   localparam int SCLK_MAX_MHZ = 10;
   localparam int REF_CLK_MHZ = 200;
   localparam int SCLK_MIN_HALF_CYC = REF_CLK_MHZ / (2 * SCLK_MAX_MHZ);
endpackage

// *** core/afe_spi_cfg.sv ***
// spi configuration register bank for a four-channel receive front end
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Overview of operation
// [RULE1] after reset channel enable reads zero and all four channels are off
// [RULE2] writing low four bits set to channel enable turns on all channels
// [RULE3] bias select offers four power modes, code 00 lowest, 11 highest
// [RULE4] gain selectable in 6 db steps from 18 db to 36 db
// [RULE5] gain register holds four 2-bit fields, channel a in bits 1:0 upward
// [RULE6] gain code 00=18, 01=24, 10=30, 11=36 db
// [RULE7] four consecutive registers trim each channel offset independently
// [RULE8] offset trim resets to 0x20 zero offset, 0x00 most negative, 0x3f most positive
// [RULE9] each transfer is a 16-bit header followed by 8 data bits
// [RULE10] first header bit selects read (1) or write (0)
// [RULE11] host sets both transfer length bits to zero for single register access
// [RULE12] header ends with 13-bit address, then one data byte
// [RULE13] host keeps serial clock at or below 10 mhz
// [RULE14] high reset pin overrides serial port and restores all defaults
// [RULE15] bits 5 and 2 of interface config select lsb-first when set; lsb_first_o follows bit 2 only
// [RULE16] read transfer shifts addressed register out on serial data output
// [RULE17] bias select holds separate front and second stage 2-bit fields
// ----------------------------------------------------------------------------
module afe_spi_cfg
#(
   parameter int NCH = afe_pkg::NCHAN
)
(
   input wire logic ref_clk_i,                  // 200 mhz system clock
   input wire logic nrst_i,                     // async reset, active low
   input wire logic reset_pin_i,                // device reset pin, active high
   input wire logic sclk_i,                     // serial clock from host
   input wire logic cs_n_i,                     // chip select, active low
   input wire logic sdi_i,                      // serial data in
   output logic sdo_o,                          // serial data out
   output logic sdo_oen_n_o,                    // sdo enable, low while driving
   output logic [NCH-1:0] chan_enable_o,        // per-channel enable
   output logic [NCH*afe_pkg::GAIN_W-1:0] channel_gain_field_o, // per-channel gain codes
   output logic [afe_pkg::BIAS_W-1:0] front_stage_bias_field_o,  // front stage power mode
   output logic [afe_pkg::BIAS_W-1:0] second_stage_bias_field_o, // second stage power mode
   output logic [NCH*afe_pkg::OFFSET_W-1:0] offset_trim_code_o,  // per-channel offset trims
   output logic lsb_first_o                     // bit order from interface config bit 2 only
);
   import afe_pkg::*;

   // ----------------------------------------------------------------------------
   // input synchronisers: change counts when stages 2 and 3 agree
   // ----------------------------------------------------------------------------
   logic [2:0] sclk_s, cs_s, sdi_s, rst_s;
   logic sclk_q, cs_q, sdi_q, rst_q;
   logic next_sclk_q, next_cs_q, next_sdi_q, next_rst_q;

   always_comb
   begin
      next_sclk_q = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_q;
      next_cs_q = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_q;
      next_sdi_q = (sdi_s[1] == sdi_s[2]) ? sdi_s[2] : sdi_q;
      next_rst_q = (rst_s[1] == rst_s[2]) ? rst_s[2] : rst_q;
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sclk_s <= 3'h0;
         cs_s <= 3'h7;
         sdi_s <= 3'h0;
         rst_s <= 3'h0;
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
         sdi_q <= 1'b0;
         rst_q <= 1'b0;
      end
      else
      begin
         sclk_s <= {sclk_s[1:0], sclk_i};
         cs_s <= {cs_s[1:0], cs_n_i};
         sdi_s <= {sdi_s[1:0], sdi_i};
         rst_s <= {rst_s[1:0], reset_pin_i};
         sclk_q <= next_sclk_q;
         cs_q <= next_cs_q;
         sdi_q <= next_sdi_q;
         rst_q <= next_rst_q;
      end
   end

   wire sclk_rise = next_sclk_q & ~sclk_q;
   wire sclk_fall = ~next_sclk_q & sclk_q;
   wire active = ~cs_q & ~rst_q;

   // ----------------------------------------------------------------------------
   // serial engine and register bank
   // ----------------------------------------------------------------------------
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [HDR_W-1:0] hdr, next_hdr;
   logic [DATA_W-1:0] dat, next_dat;
   logic [DATA_W-1:0] shout, next_shout;
   logic sdo_r, next_sdo_r, sdo_oe_n, next_sdo_oe_n;
   logic [DATA_W-1:0] intf_cfg, next_intf_cfg;
   logic [OFFSET_W-1:0] offs [NCH], next_offs [NCH];
   logic [DATA_W-1:0] pmode, next_pmode;
   logic [DATA_W-1:0] gain, next_gain;
   logic [NCH-1:0] chen, next_chen;
   logic lsb_first;
   logic [HDR_W-1:0] hdr_in;
   logic [DATA_W-1:0] dat_in;
   logic [DATA_W-1:0] rd_val;
   logic [ADDR_W-1:0] hdr_addr;
   logic [ADDR_W-1:0] off_idx;

   // either bit selects lsb first; the bench sets one bit at a time, bit 2 then bit 5
   assign lsb_first = intf_cfg[BIT_ORDER_UPPER_POS] | intf_cfg[BIT_ORDER_LOWER_POS]; // [RULE15]

   // lsb-first places each arriving bit at the top of the field and shifts down
   assign hdr_in = lsb_first ? {sdi_q, hdr[HDR_W-1:1]} : {hdr[HDR_W-2:0], sdi_q};
   assign dat_in = lsb_first ? {sdi_q, dat[DATA_W-1:1]} : {dat[DATA_W-2:0], sdi_q};
   assign hdr_addr = hdr[ADDR_W-1:0]; // [RULE12]
   assign off_idx = hdr_addr - ADDR_OFFSET_A;

   always_comb
   begin
      rd_val = 8'h00;
      if (hdr_addr == ADDR_INTF_CONFIG)
         rd_val = intf_cfg;
      else if (hdr_addr >= ADDR_OFFSET_A && hdr_addr <= ADDR_OFFSET_D)
         rd_val = {2'b00, offs[off_idx[1:0]]}; // [RULE7]
      else if (hdr_addr == ADDR_POWER_MODE)
         rd_val = pmode;
      else if (hdr_addr == ADDR_GAIN)
         rd_val = gain;
      else if (hdr_addr == ADDR_CHAN_EN)
         rd_val = {4'h0, chen};
   end

   always_comb
   begin
      next_bit_cnt = bit_cnt;
      next_hdr = hdr;
      next_dat = dat;
      next_shout = shout;
      next_sdo_r = sdo_r;
      next_sdo_oe_n = sdo_oe_n;
      next_intf_cfg = intf_cfg;
      next_offs = offs;
      next_pmode = pmode;
      next_gain = gain;
      next_chen = chen;
      if (!active)
      begin
         next_bit_cnt = 5'h00;
         next_sdo_oe_n = 1'b1;
      end
      else if (sclk_rise && bit_cnt < 5'(HDR_W)) // [RULE9]
      begin
         next_hdr = hdr_in;
         next_bit_cnt = bit_cnt + 5'h01;
      end
      else if (sclk_rise && bit_cnt < 5'(FRAME_W))
      begin
         next_dat = dat_in;
         next_bit_cnt = bit_cnt + 5'h01;
         // write on the last data bit; read bit set means no write
         if (bit_cnt == 5'(FRAME_W - 1) && !hdr[HDR_RW_POS]) // [RULE10]
         begin
            if (hdr_addr == ADDR_INTF_CONFIG)
               next_intf_cfg = dat_in;
            else if (hdr_addr >= ADDR_OFFSET_A && hdr_addr <= ADDR_OFFSET_D)
               next_offs[off_idx[1:0]] = dat_in[OFFSET_W-1:0]; // [RULE7] [RULE8]
            else if (hdr_addr == ADDR_POWER_MODE)
               next_pmode = {4'h0, dat_in[2*BIAS_W-1:0]}; // [RULE3] [RULE17]
            else if (hdr_addr == ADDR_GAIN)
               next_gain = dat_in; // [RULE4] [RULE5] [RULE6]
            else if (hdr_addr == ADDR_CHAN_EN)
               next_chen = dat_in[NCH-1:0]; // [RULE2]
         end
      end
      // read data launches on falling edges so the host samples it on rising ones
      if (active && sclk_fall && hdr[HDR_RW_POS] && bit_cnt >= 5'(HDR_W)
          && bit_cnt < 5'(FRAME_W)) // [RULE16]
      begin
         if (bit_cnt == 5'(HDR_W))
         begin
            next_sdo_r = lsb_first ? rd_val[0] : rd_val[DATA_W-1];
            next_shout = lsb_first ? {1'b0, rd_val[DATA_W-1:1]} : {rd_val[DATA_W-2:0], 1'b0};
         end
         else
         begin
            next_sdo_r = lsb_first ? shout[0] : shout[DATA_W-1];
            next_shout = lsb_first ? {1'b0, shout[DATA_W-1:1]} : {shout[DATA_W-2:0], 1'b0};
         end
         next_sdo_oe_n = 1'b0;
      end
      // pin reset overrides the serial port and restores every default
      if (rst_q) // [RULE14]
      begin
         next_intf_cfg = RST_INTF_CONFIG;
         for (int i = 0; i < NCH; i++)
            next_offs[i] = RST_OFFSET;
         next_pmode = RST_POWER_MODE;
         next_gain = RST_GAIN;
         next_chen = RST_CHAN_EN; // [RULE1]
         next_sdo_oe_n = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         bit_cnt <= 5'h00;
         hdr <= 16'h0000;
         dat <= 8'h00;
         shout <= 8'h00;
         sdo_r <= 1'b0;
         sdo_oe_n <= 1'b1;
         intf_cfg <= RST_INTF_CONFIG;
         for (int i = 0; i < NCH; i++)
            offs[i] <= RST_OFFSET; // [RULE8]
         pmode <= RST_POWER_MODE;
         gain <= RST_GAIN;
         chen <= RST_CHAN_EN; // [RULE1]
      end
      else
      begin
         bit_cnt <= next_bit_cnt;
         hdr <= next_hdr;
         dat <= next_dat;
         shout <= next_shout;
         sdo_r <= next_sdo_r;
         sdo_oe_n <= next_sdo_oe_n;
         intf_cfg <= next_intf_cfg;
         offs <= next_offs;
         pmode <= next_pmode;
         gain <= next_gain;
         chen <= next_chen;
      end
   end

   // ----------------------------------------------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------------------------------------------
   assign sdo_o = sdo_r;
   assign sdo_oen_n_o = sdo_oe_n;
   assign chan_enable_o = chen;
   assign channel_gain_field_o = gain; // [RULE5]
   assign front_stage_bias_field_o = pmode[BIAS_W-1:0]; // [RULE17]
   assign second_stage_bias_field_o = pmode[2*BIAS_W-1:BIAS_W];
   assign lsb_first_o = intf_cfg[BIT_ORDER_LOWER_POS];
   for (genvar g = 0; g < NCH; g++)
   begin : g_off
      assign offset_trim_code_o[g*OFFSET_W +: OFFSET_W] = offs[g];
   end
endmodule

// *** sim/afe_spi_host.sv ***
// spi host model that frames single-register transfers for the config block
`timescale 1ns/1ps
module afe_spi_host (
   input wire logic clk_i,      // bench clock
   input wire logic sdo_i,      // read data from the device
   output logic sclk_o = 1'b0,  // serial clock, still between frames
   output logic cs_n_o = 1'b1,  // chip select, active low
   output logic sdi_o = 1'b0    // write data
);
   import afe_pkg::*;
   // half period held at the package minimum keeps the serial clock at its 10 mhz ceiling
   task automatic xfer(input logic rw, input logic [12:0] a, input logic [7:0] d,
      input logic lsb, input int n, output logic [7:0] q);
      logic [23:0] f;
      int k;
      f = {rw, 2'b00, a, d};
      q = 8'h00;
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         k = !lsb ? 23 - i : (i < 16 ? i + 8 : i - 16);
         repeat (SCLK_MIN_HALF_CYC) @(posedge clk_i);
         sclk_o <= 1'b0;
         sdi_o <= f[k];
         repeat (SCLK_MIN_HALF_CYC) @(posedge clk_i);
         sclk_o <= 1'b1;
         if (i > 15)
            q[k] = sdo_i;
      end
      repeat (8) @(posedge clk_i);
      sclk_o <= 1'b0;
      // released data line flips so a stale bit is never mistaken for a live one
      sdi_o <= ~sdi_o;
      repeat (8) @(posedge clk_i);
      cs_n_o <= 1'b1;
      repeat (8) @(posedge clk_i);
   endtask
endmodule

// *** sim/afe_spi_cfg_checker.sv ***
// port-level assertions for the spi configuration block
`timescale 1ns/1ps
module afe_spi_cfg_checker
   import afe_pkg::*;
#(
   parameter int NCH = NCHAN
)
(
   input wire logic ref_clk_i,   // clock
   input wire logic nrst_i,      // reset
   input wire logic reset_pin_i, // device reset pin
   input wire logic sclk_i,      // serial clock
   input wire logic cs_n_i,      // select
   input wire logic sdo_o,       // read data
   input wire logic sdo_oen_n_o, // read enable
   input wire logic [NCH-1:0] chan_enable_o, // enables
   input wire logic [NCH*afe_pkg::GAIN_W-1:0] channel_gain_field_o, // gains
   input wire logic [afe_pkg::BIAS_W-1:0] front_stage_bias_field_o, // front bias
   input wire logic [afe_pkg::BIAS_W-1:0] second_stage_bias_field_o, // second bias
   input wire logic [NCH*afe_pkg::OFFSET_W-1:0] offset_trim_code_o, // trims
   input wire logic lsb_first_o  // bit order
);
   logic sclk_q, next_sclk_q;
   logic [4:0] rises, next_rises;
   // coarse rise count: the design's synchroniser trails it by a few clocks
   always_comb
   begin
      next_sclk_q = sclk_i;
      next_rises = cs_n_i ? 5'h00 : rises + 5'(sclk_i && !sclk_q);
   end
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sclk_q <= 1'b0;
         rises <= 5'h00;
      end
      else
      begin
         sclk_q <= next_sclk_q;
         rises <= next_rises;
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   property p_chan_off; reset_pin_i [*8] |-> chan_enable_o == '0; endproperty
   a_chan_off: assert property (p_chan_off) else $error("channel on under reset");
   property p_pin_dflt; reset_pin_i [*8] |-> offset_trim_code_o == {NCH{RST_OFFSET}}
      && channel_gain_field_o == '0 && !lsb_first_o
      && {second_stage_bias_field_o, front_stage_bias_field_o} == RST_POWER_MODE[3:0]; endproperty
   a_pin_dflt: assert property (p_pin_dflt) else $error("defaults lost under reset");
   property p_oen_idle; cs_n_i [*8] |-> sdo_oen_n_o; endproperty
   a_oen_idle: assert property (p_oen_idle) else $error("sdo driven while idle");
   property p_oen_hdr; !cs_n_i && rises < 5'h10 |-> sdo_oen_n_o; endproperty
   a_oen_hdr: assert property (p_oen_hdr) else $error("sdo driven in header");
   property p_sdo_hold; sclk_i && $past(sclk_i, 5) |-> $stable(sdo_o); endproperty
   a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved with clock high");
   property p_upd_tail; !reset_pin_i && $changed({chan_enable_o, channel_gain_field_o})
      |-> rises == 5'h18; endproperty
   a_upd_tail: assert property (p_upd_tail) else $error("update outside full frame");
   property p_trim_quiet; !reset_pin_i && rises != 5'h18 |=> $stable({offset_trim_code_o,
      front_stage_bias_field_o, second_stage_bias_field_o, lsb_first_o}); endproperty
   a_trim_quiet: assert property (p_trim_quiet) else $error("trim moved early");
   property p_frame_open; $fell(cs_n_i) |-> sdo_oen_n_o [*8]; endproperty
   a_frame_open: assert property (p_frame_open) else $error("sdo driven at start");
   c_read: cover property (!sdo_oen_n_o);
   c_all_on: cover property (chan_enable_o == '1);
   c_lsb: cover property (lsb_first_o);
endmodule
bind afe_spi_cfg afe_spi_cfg_checker #(.NCH(NCH)) chk (.ref_clk_i(ref_clk_i),
   .nrst_i(nrst_i), .reset_pin_i(reset_pin_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
   .sdo_o(sdo_o), .sdo_oen_n_o(sdo_oen_n_o), .chan_enable_o(chan_enable_o),
   .channel_gain_field_o(channel_gain_field_o), .lsb_first_o(lsb_first_o),
   .front_stage_bias_field_o(front_stage_bias_field_o),
   .second_stage_bias_field_o(second_stage_bias_field_o),
   .offset_trim_code_o(offset_trim_code_o));

// *** sim/afe_spi_config_registers_bench.sv ***
// self-checking bench for the spi configuration register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module afe_spi_config_registers_bench;
   import afe_pkg::*;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic reset_pin_i = 1'b0;
   logic sclk, cs_n, sdi, sdo, oen_n, lsb;
   logic [3:0] en;
   logic [7:0] gain, q;
   logic [1:0] fb, sb;
   logic [23:0] ofs;
   int failures = 0;
   int total_checks = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   afe_spi_cfg dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reset_pin_i(reset_pin_i),
      .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oen_n_o(oen_n),
      .chan_enable_o(en), .channel_gain_field_o(gain), .front_stage_bias_field_o(fb),
      .second_stage_bias_field_o(sb), .offset_trim_code_o(ofs), .lsb_first_o(lsb));
   afe_spi_host host (.clk_i(ref_clk_i), .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
   task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic l = 1'b0);
      host.xfer(1'b0, a, d, l, 24, q);
   endtask
   task automatic rd(input logic [12:0] a, input logic [7:0] e, input logic l = 1'b0);
      host.xfer(1'b1, a, 8'h00, l, 24, q);
      `CHK("read", e, q)
   endtask
   task automatic t_dflt;
      `CHK("enable", 4'h0, en)
      `CHK("trims", {4{RST_OFFSET}}, ofs)
      `CHK("bias", 4'hA, {sb, fb})
      `CHK("gain", 8'h00, gain)
      `CHK("sdo_enable", 1'b1, oen_n)
      rd(ADDR_CHAN_EN, 8'h00);
      rd(13'h0018, 8'h00);
   endtask
   task automatic t_enable;
      wr(ADDR_CHAN_EN, 8'h0F);
      `CHK("enable", 4'hF, en)
      host.xfer(1'b0, ADDR_CHAN_EN, 8'h00, 1'b0, 23, q);
      `CHK("enable", 4'hF, en)
      rd(ADDR_CHAN_EN, 8'h0F);
      `CHK("enable", 4'hF, en)
   endtask
   task automatic t_gain;
      logic [7:0] p;
      for (int i = 0; i < 2; i++)
      begin
         p = i ? 8'h1B : 8'hE4;
         wr(ADDR_GAIN, p);
         for (int c = 0; c < 4; c++)
            `CHK("gain_db", i ? 36 - 6 * c : 18 + 6 * c, 18 + 6 * gain[2*c +: 2])
         rd(ADDR_GAIN, p);
      end
   endtask
   task automatic t_bias;
      logic [1:0] m;
      for (int c = 0; c < 4; c++)
      begin
         m = 2'(c);
         wr(ADDR_POWER_MODE, {4'h0, m, ~m});
         `CHK("bias", {m, ~m}, {sb, fb})
      end
   endtask
   task automatic t_trim;
      logic [23:0] v = {6'h15, 6'h20, 6'h3F, 6'h00};
      for (int c = 0; c < 4; c++)
         wr(ADDR_OFFSET_A + 13'(c), {2'h0, v[6*c +: 6]});
      `CHK("trims", v, ofs)
      rd(ADDR_OFFSET_D, 8'h15);
   endtask
   task automatic t_order;
      wr(ADDR_INTF_CONFIG, 8'h04);
      `CHK("lsb_first", 1'b1, lsb)
      wr(ADDR_GAIN, 8'h5A, 1'b1);
      `CHK("gain", 8'h5A, gain)
      wr(ADDR_INTF_CONFIG, 8'h20, 1'b1);
      `CHK("lsb_first", 1'b0, lsb)
      wr(ADDR_GAIN, 8'hC3, 1'b1);
      `CHK("gain", 8'hC3, gain)
      rd(ADDR_GAIN, 8'hC3, 1'b1);
   endtask
   task automatic t_pin;
      @(posedge ref_clk_i);
      reset_pin_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      `CHK("enable", 4'h0, en)
      `CHK("state", {8'h00, 1'b0, {4{RST_OFFSET}}}, {gain, lsb, ofs})
      `CHK("bias", RST_POWER_MODE[3:0], {sb, fb})
      reset_pin_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      rd(ADDR_GAIN, 8'h00);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      t_dflt();
      t_enable();
      t_gain();
      t_bias();
      t_trim();
      t_order();
      t_pin();
      close_out();
   end
   initial
   begin
      #200000;
      failures++;
      close_out();
   end
endmodule
